/* File: src/cfgsb_core_end.sv */
// How it works
// - App sends abort completion before reporting
// - Errors 2 to 5 set status, send messages
// - App reports unflagged unexpected completions
// - Posted unsupported request reported, no completion
// - App sends UR completion then reports
// - Header-log bit accompanies a reported error when a header is logged
// - Header written first, four words, MSW first
// - Pending flag held while completions awaited
// - Index advances each clock, slice presented
// - Slices presented in round-robin order
// - Status vector refreshed every clock
// - Bypass mode removes index, data, status
// - Device and slot status bits at top
// - Link status and de-emphasis mapped
// - Primary, secondary and root status mapped
// - Hot-plug zero outside root-port slot mode
// - Hot-plug bits meanings; absent features zero
// - Power controller status sets command completed
// - Slices 0 to 4 layout
// - Slices 5 to F layout
// - Root-only fields zero for endpoints, except slot command completed
// - Size codes limited to 128..4096 bytes
`timescale 1ns/1ns
`default_nettype none
module cfgsb_core_end (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// Link to application end
	cfgsb_if.core LINK,
	// Mode
	input wire logic ROOT_PORT,
	input wire logic BYPASS,
	// Configuration space contents
	input wire logic [15:0] DEV_CTRL,
	input wire logic [15:0] DEVICE_CONTROL_SECOND_WORD,
	input wire logic [15:0] SLOT_CTRL,
	input wire logic [15:0] LINK_CTRL,
	input wire logic [15:0] LINK_CONTROL_SECOND_WORD,
	input wire logic [15:0] PRM_CMD,
	input wire logic [7:0] ROOT_CTRL,
	input wire logic [15:0] SEC_CTRL,
	input wire logic [7:0] SEC_BUS,
	input wire logic [7:0] SUB_BUS,
	input wire logic [63:0] MSI_ADDR,
	input wire logic [19:0] IO_BASE,
	input wire logic [19:0] IO_LIMIT,
	input wire logic [11:0] NONPREFETCH_WINDOW_BASE,
	input wire logic [11:0] NONPREFETCH_WINDOW_LIMIT,
	input wire logic [43:0] PREFETCH_WINDOW_BASE,
	input wire logic [43:0] PREFETCH_WINDOW_LIMIT,
	input wire logic [31:0] PMCSR,
	input wire logic [15:0] MSIX_CTRL,
	input wire logic [15:0] MSI_CTRL,
	input wire logic ECRC_GEN,
	input wire logic ECRC_CHECK,
	input wire logic [23:0] TC_MAP,
	input wire logic [15:0] MSI_DATA,
	input wire logic [12:0] BUS_DEV,
	// Status sources
	input wire logic [15:0] LINK_STATUS,
	input wire logic DEEMPH_LEVEL,
	input wire logic [4:0] PRIM_STS_ERR,
	input wire logic [4:0] SEC_STS_ERR,
	input wire logic SEC_MDPE,
	input wire logic MDPE,
	input wire logic [17:0] ROOT_STATUS,
	input wire logic DLL_STATE_CHANGED,
	input wire logic FATAL_DETECTED,
	input wire logic NONFATAL_DETECTED,
	input wire logic CORR_DETECTED,
	// Write-one-to-clear strobes
	input wire logic [3:0] DEV_STS_CLEAR,
	input wire logic SLOT_CC_CLEAR,
	input wire logic HDR_LOG_CLEAR,
	// Results
	output logic ERR_MSG_VALID,
	output cfgsb_pkg::err_msg_t ERR_MSG_KIND,
	output logic [127:0] HDR_LOG,
	output logic HDR_LOG_VALID,
	output logic [3:0] HP_EVENT,
	output logic CPL_PENDING_SEEN
);
	import cfgsb_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [2:0] size_code(input logic [2:0] c);
		size_code = (c > SIZE_MAX_CODE) ? SIZE_MAX_CODE : c;
	endfunction : size_code

	// ****************************************
	// State
	// ****************************************
	logic [SLICE_W-1:0] index_reg, index_next;
	logic [DATA_W-1:0] data_reg, data_next;
	logic [STATUS_W-1:0] status_reg, status_next;
	logic [DEVSTS_W-1:0] devsts_reg, devsts_next;
	logic slot_cc_reg, slot_cc_next;
	logic pwr_prev_reg, pwr_prev_next;
	logic [DATA_W-1:0] hdr_words_reg [HDR_WORDS];
	logic [DATA_W-1:0] hdr_words_next [HDR_WORDS];
	logic ack_reg, ack_next;
	logic msg_valid_reg, msg_valid_next;
	err_msg_t msg_kind_reg, msg_kind_next;
	logic [HDR_W-1:0] hdr_log_reg, hdr_log_next;
	logic hdr_valid_reg, hdr_valid_next;
	logic [3:0] hp_event_reg, hp_event_next;
	logic pending_reg, pending_next;

	// ****************************************
	// Slice rotation
	// ****************************************
	always_comb begin
		logic [15:0] devctl;
		logic rp;
		rp = ROOT_PORT;
		devctl = DEV_CTRL;
		devctl[MRRS_LSB +: 3] = size_code(DEV_CTRL[MRRS_LSB +: 3]);
		devctl[MPS_LSB +: 3] = size_code(DEV_CTRL[MPS_LSB +: 3]);
		index_next = SLICE_W'(index_reg + 1'b1);
		// Root-only fields read zero for endpoints
		case (index_next)
			4'h0: data_next = {devctl, DEVICE_CONTROL_SECOND_WORD};
			4'h1: data_next = {PAD16, rp ? SLOT_CTRL : PAD16};
			4'h2: data_next = {LINK_CTRL, LINK_CONTROL_SECOND_WORD};
			4'h3: data_next = {PAD8, PRM_CMD, rp ? ROOT_CTRL : PAD8};
			4'h4: data_next = rp ? {SEC_CTRL, SEC_BUS, SUB_BUS} : '0;
			4'h5: data_next = {MSI_ADDR[11:0], rp ? IO_BASE : 20'h00000};
			4'h6: data_next = {MSI_ADDR[43:32], rp ? IO_LIMIT : 20'h00000};
			4'h7: data_next = rp ? {PAD8, NONPREFETCH_WINDOW_BASE, NONPREFETCH_WINDOW_LIMIT} : '0;
			4'h8: data_next = rp ? PREFETCH_WINDOW_BASE[31:0] : '0;
			4'h9: data_next = {MSI_ADDR[31:12], rp ? PREFETCH_WINDOW_BASE[43:32] : 12'h000};
			4'hA: data_next = rp ? PREFETCH_WINDOW_LIMIT[31:0] : '0;
			4'hB: data_next = {MSI_ADDR[63:44], rp ? PREFETCH_WINDOW_LIMIT[43:32] : 12'h000};
			4'hC: data_next = PMCSR;
			4'hD: data_next = {MSIX_CTRL, MSI_CTRL};
			4'hE: data_next = {PAD6, ECRC_GEN, ECRC_CHECK, TC_MAP};
			4'hF: data_next = {MSI_DATA, PAD3, BUS_DEV};
			default: data_next = '0;
		endcase
		if (BYPASS) begin
			index_next = '0;
			data_next = '0;
		end
	end

	// ****************************************
	// Error status, messages, hot-plug
	// ****************************************
	always_comb begin
		logic [DEVSTS_W-1:0] set;
		logic pwr;
		logic nonfatal_ev;
		logic corr_ev;
		set = '0;
		// Aborts and posted UR are non-fatal; unexpected and non-posted UR are advisory
		nonfatal_ev = LINK.cpl_err[ERR_CA] | LINK.cpl_err[ERR_UR_POSTED];
		corr_ev = LINK.cpl_err[ERR_UNEXP] | LINK.cpl_err[ERR_UR_NONPOSTED];
		set[DS_UR] = LINK.cpl_err[ERR_UR_POSTED] | LINK.cpl_err[ERR_UR_NONPOSTED];
		set[DS_NONFATAL] = nonfatal_ev | NONFATAL_DETECTED;
		set[DS_CORR] = corr_ev | CORR_DETECTED;
		set[DS_FATAL] = FATAL_DETECTED;
		// Set wins over a clear in the same cycle
		devsts_next = (devsts_reg & ~DEV_STS_CLEAR) | set;
		msg_valid_next = nonfatal_ev | corr_ev;
		// One message per cycle; the more severe one is sent
		msg_kind_next = nonfatal_ev ? MSG_NONFATAL : (corr_ev ? MSG_CORR : MSG_NONE);
		// Hot-plug lines count only in root-port mode outside bypass
		pwr = LINK.hot_plug[HP_PWR] & ROOT_PORT & ~BYPASS;
		pwr_prev_next = pwr;
		slot_cc_next = (slot_cc_reg & ~SLOT_CC_CLEAR) | (pwr ^ pwr_prev_reg);
		hp_event_next = (ROOT_PORT & ~BYPASS) ? LINK.hot_plug[HP_PFAULT:HP_ATTN] : 4'h0;
		pending_next = LINK.cpl_pending;
		status_next = '0;
		if (!BYPASS) begin
			status_next[ST_DEVSTS_LSB +: DEVSTS_W] = devsts_reg;
			status_next[ST_SLOT_DLL] = ROOT_PORT & DLL_STATE_CHANGED;
			status_next[ST_SLOT_CC] = slot_cc_reg;
			status_next[ST_LINK_LSB +: HALF_W] = LINK_STATUS;
			status_next[ST_DEEMPH] = DEEMPH_LEVEL;
			status_next[ST_PRIM_LSB +: ERRS_W] = PRIM_STS_ERR;
			status_next[ST_SEC_MDPE] = ROOT_PORT & SEC_MDPE;
			status_next[ST_ROOT_LSB +: ROOT_STS_W] = ROOT_PORT ? ROOT_STATUS : '0;
			status_next[ST_SEC_LSB +: ERRS_W] = ROOT_PORT ? SEC_STS_ERR : '0;
			status_next[ST_MDPE] = MDPE;
		end
	end

	// ****************************************
	// Header log capture
	// ****************************************
	always_comb begin
		logic [11:0] off;
		logic hit;
		off = 12'(LINK.lmi_addr - LMI_HDR_BASE);
		hit = (LINK.lmi_addr >= LMI_HDR_BASE) && (LINK.lmi_addr <= LMI_HDR_LAST)
			&& (off[1:0] == 2'h0);
		hdr_words_next = hdr_words_reg;
		// Every write is acknowledged; only header addresses are stored
		ack_next = LINK.lmi_wren;
		if (LINK.lmi_wren && hit) begin
			hdr_words_next[off[3:2]] = LINK.lmi_din;
		end
		hdr_log_next = hdr_log_reg;
		hdr_valid_next = hdr_valid_reg & ~HDR_LOG_CLEAR;
		if (LINK.cpl_err[ERR_LOG_HDR] && (|LINK.cpl_err[ERR_UR_NONPOSTED:ERR_CA])) begin
			hdr_log_next = {hdr_words_reg[0], hdr_words_reg[1], hdr_words_reg[2],
				hdr_words_reg[3]};
			hdr_valid_next = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			index_reg <= SL_MSIDATA;
			data_reg <= '0;
			status_reg <= '0;
			devsts_reg <= '0;
			slot_cc_reg <= 1'b0;
			pwr_prev_reg <= 1'b0;
			for (int i = 0; i < HDR_WORDS; i++) begin
				hdr_words_reg[i] <= '0;
			end
			ack_reg <= 1'b0;
			msg_valid_reg <= 1'b0;
			msg_kind_reg <= MSG_NONE;
			hdr_log_reg <= '0;
			hdr_valid_reg <= 1'b0;
			hp_event_reg <= '0;
			pending_reg <= 1'b0;
		end else begin
			index_reg <= index_next;
			data_reg <= data_next;
			status_reg <= status_next;
			devsts_reg <= devsts_next;
			slot_cc_reg <= slot_cc_next;
			pwr_prev_reg <= pwr_prev_next;
			hdr_words_reg <= hdr_words_next;
			ack_reg <= ack_next;
			msg_valid_reg <= msg_valid_next;
			msg_kind_reg <= msg_kind_next;
			hdr_log_reg <= hdr_log_next;
			hdr_valid_reg <= hdr_valid_next;
			hp_event_reg <= hp_event_next;
			pending_reg <= pending_next;
		end
	end

	assign LINK.config_slice_index = index_reg;
	assign LINK.config_mux_data = data_reg;
	assign LINK.config_status_vector = status_reg;
	assign LINK.lmi_ack = ack_reg;
	assign ERR_MSG_VALID = msg_valid_reg;
	assign ERR_MSG_KIND = msg_kind_reg;
	assign HDR_LOG = hdr_log_reg;
	assign HDR_LOG_VALID = hdr_valid_reg;
	assign HP_EVENT = hp_event_reg;
	assign CPL_PENDING_SEEN = pending_reg;
endmodule : cfgsb_core_end
`default_nettype wire

/* File: src/cfgsb_pkg.sv */
package cfgsb_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int SLICE_W = 4;
	localparam int DATA_W = 32;
	localparam int STATUS_W = 53;
	localparam int CPL_ERR_W = 7;
	localparam int HP_W = 5;
	localparam int HDR_W = 128;
	localparam int HDR_WORDS = 4;
	localparam int HDR_LAST = 3;
	localparam int HALF_W = 16;
	localparam int OUTSTANDING_W = 8;

	// ****************************************
	// Completion error report bits
	// ****************************************
	localparam int ERR_CA = 2;
	localparam int ERR_UNEXP = 3;
	localparam int ERR_UR_POSTED = 4;
	localparam int ERR_UR_NONPOSTED = 5;
	localparam int ERR_LOG_HDR = 6;

	// ****************************************
	// Hot-plug bits
	// ****************************************
	localparam int HP_ATTN = 0;
	localparam int HP_PRESENCE = 1;
	localparam int HP_LATCH = 2;
	localparam int HP_PFAULT = 3;
	localparam int HP_PWR = 4;

	// ****************************************
	// Header log words over the management port
	// ****************************************
	localparam logic [11:0] LMI_HDR_BASE = 12'h81C;
	localparam logic [11:0] LMI_HDR_STEP = 12'h004;
	localparam logic [11:0] LMI_HDR_LAST = 12'h828;

	// ****************************************
	// Status vector layout
	// ****************************************
	localparam int ST_DEVSTS_LSB = 49;
	localparam int ST_SLOT_DLL = 48;
	localparam int ST_SLOT_CC = 47;
	localparam int ST_LINK_LSB = 31;
	localparam int ST_DEEMPH = 30;
	localparam int ST_PRIM_LSB = 25;
	localparam int ST_SEC_MDPE = 24;
	localparam int ST_ROOT_LSB = 6;
	localparam int ST_SEC_LSB = 1;
	localparam int ST_MDPE = 0;
	localparam int ROOT_STS_W = 18;
	localparam int ERRS_W = 5;
	localparam int DEVSTS_W = 4;

	// Device status bits
	localparam int DS_UR = 3;
	localparam int DS_FATAL = 2;
	localparam int DS_NONFATAL = 1;
	localparam int DS_CORR = 0;

	// ****************************************
	// Slice indices and fields
	// ****************************************
	localparam logic [3:0] SL_DEVCTL = 4'h0;
	localparam logic [3:0] SL_TCMAP = 4'hE;
	localparam logic [3:0] SL_MSIDATA = 4'hF;
	localparam int MRRS_LSB = 12;
	localparam int MPS_LSB = 5;
	localparam int ECRC_GEN_BIT = 25;
	localparam int ECRC_CHK_BIT = 24;
	localparam int TCMAP_W = 24;
	localparam int BUSDEV_W = 13;
	localparam logic [2:0] SIZE_MAX_CODE = 3'h5;
	localparam logic [15:0] PAD16 = 16'h0000;
	localparam logic [7:0] PAD8 = 8'h00;
	localparam logic [5:0] PAD6 = 6'h00;
	localparam logic [2:0] PAD3 = 3'h0;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [1:0] {MSG_NONE, MSG_CORR, MSG_NONFATAL, MSG_FATAL} err_msg_t;
	typedef enum logic [1:0] {KIND_CA, KIND_UNEXP, KIND_UR_POSTED, KIND_UR_NONPOSTED} report_kind_t;
endpackage : cfgsb_pkg

/* File: src/cfgsb_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cfgsb_if;
	import cfgsb_pkg::*;
	logic [CPL_ERR_W-1:0] cpl_err;
	logic cpl_pending;
	logic [HP_W-1:0] hot_plug;
	logic [11:0] lmi_addr;
	logic [DATA_W-1:0] lmi_din;
	logic lmi_wren;
	logic lmi_ack;
	logic [SLICE_W-1:0] config_slice_index;
	logic [DATA_W-1:0] config_mux_data;
	logic [STATUS_W-1:0] config_status_vector;

	modport core (
		input cpl_err, cpl_pending, hot_plug, lmi_addr, lmi_din, lmi_wren,
		output lmi_ack, config_slice_index, config_mux_data, config_status_vector
	);
	modport app (
		output cpl_err, cpl_pending, hot_plug, lmi_addr, lmi_din, lmi_wren,
		input lmi_ack, config_slice_index, config_mux_data, config_status_vector
	);
endinterface : cfgsb_if
`default_nettype wire

/* File: src/cfgsb_app_end.sv */
`timescale 1ns/1ns
`default_nettype none
module cfgsb_app_end (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	// Link to core end
	cfgsb_if.app LINK,
	// Error report requests
	input wire logic REPORT_REQ,
	input wire cfgsb_pkg::report_kind_t REPORT_KIND,
	input wire logic REPORT_LOG_HDR,
	input wire logic [127:0] REPORT_HDR,
	input wire logic CPL_SENT,
	output logic REPORT_BUSY,
	// Outstanding requests
	input wire logic [7:0] OUTSTANDING_COUNT,
	// Slot lines and presence settings
	input wire logic ROOT_PORT,
	input wire logic [4:0] HP_LINES,
	input wire logic [4:0] HP_PRESENT,
	// Decoded configuration
	output logic [2:0] MAX_PAYLOAD,
	output logic [2:0] MAX_READ_REQ,
	output logic [12:0] BUS_DEV,
	output logic [23:0] TC_MAP,
	output logic ECRC_GEN,
	output logic [3:0] DEV_ERR_STATUS
);
	import cfgsb_pkg::*;

	typedef enum {ST_IDLE, ST_WAIT_CPL, ST_LMI_WRITE, ST_LMI_WAIT, ST_REPORT} app_state_t;

	function automatic logic [DATA_W-1:0] hdr_word(input logic [HDR_W-1:0] h,
		input logic [1:0] w);
		hdr_word = h[(HDR_LAST - int'(w)) * DATA_W +: DATA_W];
	endfunction : hdr_word

	// ****************************************
	// State
	// ****************************************
	app_state_t state_reg, state_next;
	report_kind_t kind_reg, kind_next;
	logic log_reg, log_next;
	logic [HDR_W-1:0] hdr_reg, hdr_next;
	logic [1:0] word_reg, word_next;
	logic busy_reg, busy_next;
	logic [CPL_ERR_W-1:0] err_reg, err_next;
	logic wren_reg, wren_next;
	logic [11:0] addr_reg, addr_next;
	logic [DATA_W-1:0] din_reg, din_next;
	logic pending_reg, pending_next;
	logic [HP_W-1:0] hp_reg, hp_next;

	// ****************************************
	// Report sequencer
	// ****************************************
	always_comb begin
		logic [CPL_ERR_W-1:0] one;
		state_next = state_reg;
		kind_next = kind_reg;
		log_next = log_reg;
		hdr_next = hdr_reg;
		word_next = word_reg;
		err_next = '0;
		wren_next = 1'b0;
		addr_next = addr_reg;
		din_next = din_reg;
		one = '0;
		case (state_reg)
			ST_IDLE: begin
				if (REPORT_REQ) begin
					kind_next = REPORT_KIND;
					log_next = REPORT_LOG_HDR;
					hdr_next = REPORT_HDR;
					word_next = 2'h0;
					// Report waits until the completion has gone
					if (REPORT_KIND == KIND_CA || REPORT_KIND == KIND_UR_NONPOSTED) begin
						state_next = ST_WAIT_CPL;
					end else begin
						state_next = REPORT_LOG_HDR ? ST_LMI_WRITE : ST_REPORT;
					end
				end
			end
			ST_WAIT_CPL: begin
				if (CPL_SENT) begin
					state_next = log_reg ? ST_LMI_WRITE : ST_REPORT;
				end
			end
			ST_LMI_WRITE: begin
				// Header goes first, most significant word first
				wren_next = 1'b1;
				addr_next = LMI_HDR_BASE + (LMI_HDR_STEP * {10'h000, word_reg});
				din_next = hdr_word(hdr_reg, word_reg);
				state_next = ST_LMI_WAIT;
			end
			ST_LMI_WAIT: begin
				if (LINK.lmi_ack) begin
					if (word_reg == 2'(HDR_LAST)) begin
						state_next = ST_REPORT;
					end else begin
						word_next = 2'(word_reg + 1'b1);
						state_next = ST_LMI_WRITE;
					end
				end
			end
			ST_REPORT: begin
				case (kind_reg)
					KIND_CA: one[ERR_CA] = 1'b1;
					KIND_UNEXP: one[ERR_UNEXP] = 1'b1;
					KIND_UR_POSTED: one[ERR_UR_POSTED] = 1'b1;
					KIND_UR_NONPOSTED: one[ERR_UR_NONPOSTED] = 1'b1;
					default: one = '0;
				endcase
				one[ERR_LOG_HDR] = log_reg;
				err_next = one;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		busy_next = (state_next != ST_IDLE);
		pending_next = (OUTSTANDING_COUNT != '0);
		// Endpoints and absent features drive zeros
		hp_next = ROOT_PORT ? (HP_LINES & HP_PRESENT) : '0;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			state_reg <= ST_IDLE;
			kind_reg <= KIND_CA;
			log_reg <= 1'b0;
			hdr_reg <= '0;
			word_reg <= '0;
			busy_reg <= 1'b0;
			err_reg <= '0;
			wren_reg <= 1'b0;
			addr_reg <= '0;
			din_reg <= '0;
			pending_reg <= 1'b0;
			hp_reg <= '0;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			log_reg <= log_next;
			hdr_reg <= hdr_next;
			word_reg <= word_next;
			busy_reg <= busy_next;
			err_reg <= err_next;
			wren_reg <= wren_next;
			addr_reg <= addr_next;
			din_reg <= din_next;
			pending_reg <= pending_next;
			hp_reg <= hp_next;
		end
	end

	// ****************************************
	// Slice decode
	// ****************************************
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			MAX_PAYLOAD <= '0;
			MAX_READ_REQ <= '0;
			BUS_DEV <= '0;
			TC_MAP <= '0;
			ECRC_GEN <= 1'b0;
			DEV_ERR_STATUS <= '0;
		end else begin
			if (LINK.config_slice_index == SL_DEVCTL) begin
				MAX_PAYLOAD <= LINK.config_mux_data[HALF_W + MPS_LSB +: 3];
				MAX_READ_REQ <= LINK.config_mux_data[HALF_W + MRRS_LSB +: 3];
			end
			if (LINK.config_slice_index == SL_TCMAP) begin
				TC_MAP <= LINK.config_mux_data[TCMAP_W-1:0];
				ECRC_GEN <= LINK.config_mux_data[ECRC_GEN_BIT];
			end
			if (LINK.config_slice_index == SL_MSIDATA) begin
				BUS_DEV <= LINK.config_mux_data[BUSDEV_W-1:0];
			end
			DEV_ERR_STATUS <= LINK.config_status_vector[ST_DEVSTS_LSB +: DEVSTS_W];
		end
	end

	assign LINK.cpl_err = err_reg;
	assign LINK.cpl_pending = pending_reg;
	assign LINK.hot_plug = hp_reg;
	assign LINK.lmi_addr = addr_reg;
	assign LINK.lmi_din = din_reg;
	assign LINK.lmi_wren = wren_reg;
	assign REPORT_BUSY = busy_reg;
endmodule : cfgsb_app_end
`default_nettype wire

/* File: bench/cfgsb_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module cfgsb_chk (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic BYPASS,
	// Link signals
	input wire logic [cfgsb_pkg::CPL_ERR_W-1:0] cpl_err,
	input wire logic [cfgsb_pkg::HP_W-1:0] hot_plug,
	input wire logic [11:0] lmi_addr,
	input wire logic lmi_wren,
	input wire logic lmi_ack,
	input wire logic [cfgsb_pkg::SLICE_W-1:0] config_slice_index,
	input wire logic [cfgsb_pkg::STATUS_W-1:0] config_status_vector
);
	import cfgsb_pkg::*;
	default clocking cb @(posedge MCLK);
	endclocking
	// Bypass stops the slice bus and status on purpose
	default disable iff (!RST_B || BYPASS);
	// ****************************************
	// Slice rotation
	// ****************************************
	index_step_a: assert property ($past(RST_B) |->
		config_slice_index == $past(config_slice_index) + 4'h1)
		else $error("slice index did not step by one");
	index_wrap_a: assert property (config_slice_index == 4'hF |=>
		config_slice_index == 4'h0)
		else $error("slice index did not wrap to zero");
	// ****************************************
	// Header writes and error reports
	// ****************************************
	write_ack_a: assert property (lmi_wren |=> lmi_ack && !lmi_wren)
		else $error("header write not acknowledged next cycle");
	ack_cause_a: assert property (lmi_ack |-> $past(lmi_wren))
		else $error("acknowledge without a write");
	log_last_a: assert property (lmi_wren && lmi_addr == LMI_HDR_LAST |->
		##[2:8] cpl_err[ERR_LOG_HDR])
		else $error("log bit missing after last header word");
	log_with_err_a: assert property (cpl_err[ERR_LOG_HDR] |->
		|cpl_err[ERR_UR_NONPOSTED:ERR_CA])
		else $error("log bit without an error bit");
	ur_status_a: assert property (cpl_err[ERR_UR_POSTED] || cpl_err[ERR_UR_NONPOSTED] |->
		##2 config_status_vector[ST_DEVSTS_LSB + DS_UR])
		else $error("unsupported request status not set");
	nonfatal_status_a: assert property (cpl_err[ERR_CA] || cpl_err[ERR_UR_POSTED] |->
		##2 config_status_vector[ST_DEVSTS_LSB + DS_NONFATAL])
		else $error("non-fatal status not set");
	corr_status_a: assert property (cpl_err[ERR_UNEXP] |->
		##2 config_status_vector[ST_DEVSTS_LSB + DS_CORR])
		else $error("correctable status not set");
	slot_cc_a: assert property ($changed(hot_plug[HP_PWR]) |->
		##2 config_status_vector[ST_SLOT_CC])
		else $error("command completed not set");
endmodule : cfgsb_chk
`default_nettype wire

/* File: bench/test_pcie_cfg_sideband_export.sv */
`timescale 1ns/1ns
`default_nettype none
module test_pcie_cfg_sideband_export;
	import cfgsb_pkg::*;
	localparam logic [31:0] PA = 32'h3C5A96E7;
	localparam logic [3:0] EXP_DS [4] = '{4'h2, 4'h1, 4'hA, 4'h9};
	localparam err_msg_t EXP_MSG [4] = '{MSG_NONFATAL, MSG_CORR, MSG_NONFATAL, MSG_CORR};
	logic MCLK, RST_B, ROOT_PORT, BYPASS, ECRC_GEN, ECRC_CHECK, DEEMPH_LEVEL, SEC_MDPE, MDPE;
	logic DLL_STATE_CHANGED, FATAL_DETECTED, NONFATAL_DETECTED, CORR_DETECTED, SLOT_CC_CLEAR;
	logic HDR_LOG_CLEAR, ERR_MSG_VALID, HDR_LOG_VALID, CPL_PENDING_SEEN, REPORT_REQ;
	logic REPORT_LOG_HDR, CPL_SENT, REPORT_BUSY, app_gen;
	logic [15:0] DEV_CTRL, DEVICE_CONTROL_SECOND_WORD, SLOT_CTRL, LINK_CTRL, PRM_CMD, SEC_CTRL;
	logic [15:0] LINK_CONTROL_SECOND_WORD, MSIX_CTRL, MSI_CTRL, MSI_DATA, LINK_STATUS;
	logic [7:0] ROOT_CTRL, SEC_BUS, SUB_BUS, OUTSTANDING_COUNT;
	logic [63:0] MSI_ADDR;
	logic [19:0] IO_BASE, IO_LIMIT;
	logic [11:0] NONPREFETCH_WINDOW_BASE, NONPREFETCH_WINDOW_LIMIT;
	logic [43:0] PREFETCH_WINDOW_BASE, PREFETCH_WINDOW_LIMIT;
	logic [31:0] PMCSR;
	logic [23:0] TC_MAP, app_tc;
	logic [12:0] BUS_DEV, app_bus_dev;
	logic [4:0] PRIM_STS_ERR, SEC_STS_ERR, HP_LINES, HP_PRESENT;
	logic [17:0] ROOT_STATUS;
	logic [3:0] DEV_STS_CLEAR, HP_EVENT, DEV_ERR_STATUS;
	logic [2:0] MAX_PAYLOAD, MAX_READ_REQ;
	logic [127:0] HDR_LOG, REPORT_HDR;
	err_msg_t ERR_MSG_KIND, last_kind;
	report_kind_t REPORT_KIND;
	int fails = 0, cmp_count = 0, msg_n = 0;

	cfgsb_if LINK();
	cfgsb_core_end i_cfgsb_core_end(.*);
	cfgsb_app_end i_cfgsb_app_end(.*, .BUS_DEV(app_bus_dev), .TC_MAP(app_tc), .ECRC_GEN(app_gen));
	cfgsb_chk i_cfgsb_chk(.MCLK(MCLK), .RST_B(RST_B), .BYPASS(BYPASS), .cpl_err(LINK.cpl_err),
		.hot_plug(LINK.hot_plug), .lmi_addr(LINK.lmi_addr), .lmi_wren(LINK.lmi_wren),
		.lmi_ack(LINK.lmi_ack), .config_slice_index(LINK.config_slice_index),
		.config_status_vector(LINK.config_status_vector));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(negedge MCLK);
	endtask : tick
	task automatic chk(input string nm, input logic [128:0] got, input logic [128:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_of_test;
		if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic cfg(input logic [31:0] p);
		{DEV_CTRL, DEVICE_CONTROL_SECOND_WORD, SLOT_CTRL, LINK_CTRL, LINK_CONTROL_SECOND_WORD,
			PRM_CMD, ROOT_CTRL, SEC_CTRL, SEC_BUS, SUB_BUS, MSI_ADDR, IO_BASE, IO_LIMIT,
			NONPREFETCH_WINDOW_BASE, NONPREFETCH_WINDOW_LIMIT, PREFETCH_WINDOW_BASE,
			PREFETCH_WINDOW_LIMIT, PMCSR, MSIX_CTRL, MSI_CTRL, ECRC_GEN, ECRC_CHECK, TC_MAP,
			MSI_DATA, BUS_DEV, LINK_STATUS, DEEMPH_LEVEL, PRIM_STS_ERR, SEC_STS_ERR, SEC_MDPE,
			MDPE, ROOT_STATUS, DLL_STATE_CHANGED} = 519'({17{p}});
		// Size codes above the legal range on one pass
		DEV_CTRL[14:12] = p[2:0];
		DEV_CTRL[7:5] = p[2:0];
	endtask : cfg
	function automatic logic [2:0] lim(input logic [2:0] v);
		return (v > SIZE_MAX_CODE) ? SIZE_MAX_CODE : v;
	endfunction : lim
	function automatic logic [31:0] slice(input logic [3:0] i);
		logic [15:0] dc;
		dc = {DEV_CTRL[15], lim(DEV_CTRL[14:12]), DEV_CTRL[11:8], lim(DEV_CTRL[7:5]), DEV_CTRL[4:0]};
		case (i)
			4'h0: return {dc, DEVICE_CONTROL_SECOND_WORD};
			4'h1: return {16'h0000, SLOT_CTRL};
			4'h2: return {LINK_CTRL, LINK_CONTROL_SECOND_WORD};
			4'h3: return {8'h00, PRM_CMD, ROOT_CTRL};
			4'h4: return {SEC_CTRL, SEC_BUS, SUB_BUS};
			4'h5: return {MSI_ADDR[11:0], IO_BASE};
			4'h6: return {MSI_ADDR[43:32], IO_LIMIT};
			4'h7: return {8'h00, NONPREFETCH_WINDOW_BASE, NONPREFETCH_WINDOW_LIMIT};
			4'h8: return PREFETCH_WINDOW_BASE[31:0];
			4'h9: return {MSI_ADDR[31:12], PREFETCH_WINDOW_BASE[43:32]};
			4'hA: return PREFETCH_WINDOW_LIMIT[31:0];
			4'hB: return {MSI_ADDR[63:44], PREFETCH_WINDOW_LIMIT[43:32]};
			4'hC: return PMCSR;
			4'hD: return {MSIX_CTRL, MSI_CTRL};
			4'hE: return {6'h00, ECRC_GEN, ECRC_CHECK, TC_MAP};
			default: return {MSI_DATA, 3'b000, BUS_DEV};
		endcase
	endfunction : slice

	always @(posedge MCLK) begin
		if (ERR_MSG_VALID === 1'b1) begin
			last_kind <= ERR_MSG_KIND;
			msg_n <= msg_n + 1;
		end
	end
	initial begin
		MCLK = 1'b0;
		forever #10 MCLK = ~MCLK;
	end
	initial begin
		repeat (5000) @(posedge MCLK);
		fails++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		RST_B = 1'b0;
		{ROOT_PORT, BYPASS, FATAL_DETECTED, NONFATAL_DETECTED, CORR_DETECTED} = 5'h10;
		{SLOT_CC_CLEAR, HDR_LOG_CLEAR, REPORT_REQ, REPORT_LOG_HDR, CPL_SENT} = 5'h00;
		{OUTSTANDING_COUNT, HP_LINES, HP_PRESENT, DEV_STS_CLEAR} = 22'h0;
		REPORT_HDR = 128'h0;
		REPORT_KIND = KIND_CA;
		cfg(PA);
		tick(20);
		RST_B = 1'b1;
		for (int n = 0; n < 2; n++) begin
			cfg(n ? ~PA : PA);
			tick(2);
			repeat (32) begin
				chk("slice", LINK.config_mux_data, slice(LINK.config_slice_index));
				tick(1);
			end
			chk("status", LINK.config_status_vector[48:0], {DLL_STATE_CHANGED, 1'b0, LINK_STATUS,
				DEEMPH_LEVEL, PRIM_STS_ERR, SEC_MDPE, ROOT_STATUS, SEC_STS_ERR, MDPE});
			chk("sizes", {MAX_READ_REQ, MAX_PAYLOAD}, {lim(DEV_CTRL[14:12]), lim(DEV_CTRL[7:5])});
			chk("slice_f", {app_gen, app_tc, app_bus_dev}, {ECRC_GEN, TC_MAP, BUS_DEV});
		end
		// Two kinds wait on the completion, two log a header
		for (int k = 0; k < 4; k++) begin
			DEV_STS_CLEAR = 4'hF;
			tick(1);
			DEV_STS_CLEAR = 4'h0;
			REPORT_HDR = {32'hA0000000 + k, 32'hB1111111, 32'hC2222222, 32'hD3333333};
			REPORT_KIND = report_kind_t'(k);
			REPORT_LOG_HDR = k[0] ^ k[1];
			REPORT_REQ = 1'b1;
			tick(1);
			REPORT_REQ = 1'b0;
			tick(4);
			chk("busy", REPORT_BUSY, 1'b1);
			CPL_SENT = 1'b1;
			for (int w = 0; w < 40 && REPORT_BUSY !== 1'b0; w++) tick(1);
			chk("idle", REPORT_BUSY, 1'b0);
			CPL_SENT = 1'b0;
			tick(3);
			chk("devsts", LINK.config_status_vector[52:49], EXP_DS[k]);
			chk("app_devsts", DEV_ERR_STATUS, EXP_DS[k]);
			chk("msg", {msg_n, last_kind}, {k + 1, EXP_MSG[k]});
			if (REPORT_LOG_HDR) chk("hdr", {HDR_LOG_VALID, HDR_LOG}, {1'b1, REPORT_HDR});
		end
		FATAL_DETECTED = 1'b1;
		tick(1);
		FATAL_DETECTED = 1'b0;
		tick(3);
		chk("fatal", {msg_n, LINK.config_status_vector[51]}, {32'd4, 1'b1});
		OUTSTANDING_COUNT = 8'h03;
		tick(3);
		chk("pend", {LINK.cpl_pending, CPL_PENDING_SEEN}, 2'b11);
		OUTSTANDING_COUNT = 8'h00;
		tick(3);
		chk("pend", {LINK.cpl_pending, CPL_PENDING_SEEN}, 2'b00);
		{HP_PRESENT, HP_LINES} = 10'h3EF;
		tick(3);
		chk("hp", HP_EVENT, 4'hF);
		HP_PRESENT = 5'h15;
		tick(3);
		chk("hp_absent", HP_EVENT, 4'h5);
		HP_LINES = 5'h1F;
		tick(3);
		chk("slot_cc", LINK.config_status_vector[47], 1'b1);
		ROOT_PORT = 1'b0;
		tick(3);
		chk("endpoint", {LINK.hot_plug, LINK.config_status_vector[48]}, 6'h00);
		repeat (16) begin
			if (LINK.config_slice_index === 4'h1) chk("ep_slot", LINK.config_mux_data, 32'h0);
			tick(1);
		end
		BYPASS = 1'b1;
		tick(2);
		chk("bypass", {LINK.config_slice_index, LINK.config_mux_data,
			LINK.config_status_vector}, 89'h0);
		end_of_test();
	end
endmodule : test_pcie_cfg_sideband_export
`default_nettype wire
